//--- rtl/kwd_pkg.sv
// Constants and types for the keyboard wake key decoder.
// Assumes a 32-bit AXI4-Lite register bus with each register in one aligned word.
package kwd_pkg;

   localparam int ADDR_W = 10;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_MAKE1  = 8'h5F;
   localparam logic [7:0] IDX_MAKE2  = 8'h60;
   localparam logic [7:0] IDX_BRK1   = 8'h61;
   localparam logic [7:0] IDX_BRK2   = 8'h62;
   localparam logic [7:0] IDX_BRK3   = 8'h63;
   localparam logic [7:0] IDX_CFG    = 8'h64;
   localparam logic [7:0] IDX_STATUS = 8'h78;
   localparam logic [7:0] IDX_MASK   = 8'h79;
   localparam logic [7:0] IDX_CTRL   = 8'h7A;

   // Values after the full power-on reset.
   localparam logic [7:0] RST_MAKE1  = 8'hE0;
   localparam logic [7:0] RST_MAKE2  = 8'h37;
   localparam logic [7:0] RST_BRK1   = 8'hE0;
   localparam logic [7:0] RST_BRK2   = 8'hF0;
   localparam logic [7:0] RST_BRK3   = 8'h37;
   localparam logic [7:0] RST_CFG    = 8'h6C;
   localparam logic [1:0] RST_CTRL   = 2'h3;
   localparam logic [1:0] RST_STATUS = 2'h0;
   localparam logic [1:0] RST_MASK   = 2'h0;

   // Status, mask and control bit positions.
   localparam int STS_MAKE_BIT  = 0;
   localparam int STS_BREAK_BIT = 1;
   localparam int CTRL_WAKE_BIT = 0;
   localparam int CTRL_PB_BIT   = 1;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      FMT_S1_SINGLE = 2'b00,
      FMT_S1_MULTI  = 2'b01,
      FMT_S2_SINGLE = 2'b10,
      FMT_S2_MULTI  = 2'b11
   } kwd_fmt_t;

   typedef enum logic [1:0] {
      REL_ANY    = 2'b00,
      REL_RSV01  = 2'b01,
      REL_BREAK  = 2'b10,
      REL_RSV11  = 2'b11
   } kwd_rel_t;

   typedef struct packed {
      logic       lock;
      logic       fixed_one;
      kwd_rel_t   rel_sel;
      kwd_fmt_t   fmt;
      logic [1:0] fixed_zero;
   } kwd_cfg_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } kwd_scan_t;

endpackage

//--- rtl/kwd_wake_key.sv
// Keyboard wake key decoder: register file on AXI4-Lite and scan code matchers.
// Assumes scan bytes arrive one per valid cycle, synchronous to aclk, and that the
// standby, main and bus resets are synchronous active-high inputs.
`timescale 1ns/1ns
`default_nettype none

module kwd_wake_key (
   // Clock, enable and full power-on reset
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic                        ce,
   // Partial resets, active high
   input  wire logic                        standby_por,
   input  wire logic                        main_por,
   input  wire logic                        bus_reset,
   // Keyboard scan code stream
   input  wire kwd_pkg::kwd_scan_t          scan_in,
   // Events
   output logic                             keyboard_power_button_status,
   output logic                             wake_event,
   output logic                             irq,
   // AXI4-Lite write address and data
   input  wire logic [kwd_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [kwd_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready
);

   // Key registers.
   logic [7:0]       make1;
   logic [7:0]       make2;
   logic [7:0]       brk1;
   logic [7:0]       brk2;
   logic [7:0]       brk3;
   kwd_pkg::kwd_cfg_t cfg;
   logic [1:0]       ctrl;
   logic [1:0]       status;
   logic [1:0]       mask;

   // Bus slave state.
   logic             aw_full;
   logic             w_full;
   logic [7:0]       aw_idx;
   logic [7:0]       w_byte;
   logic             w_lane0;

   // Write decode.
   wire wr_fire    = ce & aw_full & w_full & ~s_axi_bvalid;
   wire wr_any     = wr_fire & w_lane0;
   wire key_range  = (aw_idx >= kwd_pkg::IDX_MAKE1) & (aw_idx <= kwd_pkg::IDX_CFG);
   wire key_wr_ok  = wr_any & key_range & ~cfg.lock;
   wire wr_make1   = key_wr_ok & (aw_idx == kwd_pkg::IDX_MAKE1);
   wire wr_make2   = key_wr_ok & (aw_idx == kwd_pkg::IDX_MAKE2);
   wire wr_brk1    = key_wr_ok & (aw_idx == kwd_pkg::IDX_BRK1);
   wire wr_brk2    = key_wr_ok & (aw_idx == kwd_pkg::IDX_BRK2);
   wire wr_brk3    = key_wr_ok & (aw_idx == kwd_pkg::IDX_BRK3);
   wire wr_cfg     = key_wr_ok & (aw_idx == kwd_pkg::IDX_CFG);
   wire wr_status  = wr_any & (aw_idx == kwd_pkg::IDX_STATUS);
   wire wr_mask    = wr_any & (aw_idx == kwd_pkg::IDX_MASK);
   wire wr_ctrl    = wr_any & (aw_idx == kwd_pkg::IDX_CTRL);
   wire part_reset = standby_por | main_por | bus_reset;

   function automatic logic mapped(input logic [7:0] idx);
      mapped = ((idx >= kwd_pkg::IDX_MAKE1) && (idx <= kwd_pkg::IDX_CFG)) ||
               (idx == kwd_pkg::IDX_STATUS) || (idx == kwd_pkg::IDX_MASK) ||
               (idx == kwd_pkg::IDX_CTRL);
   endfunction

   // Handshakes stall while the enable is low so no beat is lost.
   assign s_axi_awready = ce & ~aw_full & ~s_axi_bvalid;
   assign s_axi_wready  = ce & ~w_full & ~s_axi_bvalid;
   assign s_axi_arready = ce & ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_idx  <= 8'h00;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_idx  <= s_axi_awaddr[kwd_pkg::ADDR_W-1:2];
         end else if (wr_fire) begin
            aw_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full  <= 1'b0;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_full  <= 1'b1;
            w_byte  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= kwd_pkg::RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_idx) ? kwd_pkg::RESP_OKAY : kwd_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read selection.
   wire [7:0] ar_idx  = s_axi_araddr[kwd_pkg::ADDR_W-1:2];
   wire [7:0] rd_byte =
      (ar_idx == kwd_pkg::IDX_MAKE1)  ? make1 :
      (ar_idx == kwd_pkg::IDX_MAKE2)  ? make2 :
      (ar_idx == kwd_pkg::IDX_BRK1)   ? brk1 :
      (ar_idx == kwd_pkg::IDX_BRK2)   ? brk2 :
      (ar_idx == kwd_pkg::IDX_BRK3)   ? brk3 :
      (ar_idx == kwd_pkg::IDX_CFG)    ? cfg :
      (ar_idx == kwd_pkg::IDX_STATUS) ? {6'h00, status} :
      (ar_idx == kwd_pkg::IDX_MASK)   ? {6'h00, mask} :
      (ar_idx == kwd_pkg::IDX_CTRL)   ? {6'h00, ctrl} : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= kwd_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= mapped(ar_idx) ? kwd_pkg::RESP_OKAY : kwd_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Scan code byte registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         make1 <= kwd_pkg::RST_MAKE1;
         make2 <= kwd_pkg::RST_MAKE2;
         brk1  <= kwd_pkg::RST_BRK1;
         brk2  <= kwd_pkg::RST_BRK2;
         brk3  <= kwd_pkg::RST_BRK3;
      end else if (ce) begin
         if (wr_make1) make1 <= w_byte;
         if (wr_make2) make2 <= w_byte;
         if (wr_brk1)  brk1  <= w_byte;
         if (wr_brk2)  brk2  <= w_byte;
         if (wr_brk3)  brk3  <= w_byte;
      end
   end

   // Configuration. Only the full reset loads the whole register; the partial
   // resets drop the lock alone so the programmed key survives a sleep state.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg <= kwd_pkg::RST_CFG;
      end else if (ce) begin
         if (wr_cfg) begin
            cfg <= w_byte;
         end
         if (part_reset) begin
            cfg.lock <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= kwd_pkg::RST_CTRL;
         mask <= kwd_pkg::RST_MASK;
      end else if (ce) begin
         if (wr_ctrl) ctrl <= w_byte[1:0];
         if (wr_mask) mask <= w_byte[1:0];
      end
   end

   // Sequence selection by format.
   wire [2:0][7:0] make_seq;
   wire [2:0][7:0] brk_seq;
   wire [1:0]      make_len;
   wire [1:0]      brk_len;
   wire            multi = cfg.fmt[0];
   wire            set2  = cfg.fmt[1];

   assign make_seq = multi ? {8'h00, make2, brk1} : {8'h00, 8'h00, make2};
   assign make_len = multi ? 2'h2 : 2'h1;
   assign brk_seq  =
      (cfg.fmt == kwd_pkg::FMT_S1_SINGLE) ? {8'h00, 8'h00, brk1} :
      (cfg.fmt == kwd_pkg::FMT_S1_MULTI)  ? {8'h00, brk2, brk1} :
      (cfg.fmt == kwd_pkg::FMT_S2_SINGLE) ? {8'h00, brk3, brk2} :
                                            {brk3, brk2, brk1};
   assign brk_len  = (set2 && multi) ? 2'h3 : ((set2 || multi) ? 2'h2 : 2'h1);

   logic make_hit;
   logic make_done;
   logic brk_hit;
   logic brk_done;

   kwd_seq_track u_make (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .scan    (scan_in),
      .seq     (make_seq),
      .len     (make_len),
      .hit     (make_hit),
      .done    (make_done)
   );

   kwd_seq_track u_break (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .scan    (scan_in),
      .seq     (brk_seq),
      .len     (brk_len),
      .hit     (brk_hit),
      .done    (brk_done)
   );

   // Power button level and wake pulse.
   wire pb_set = make_done & ctrl[kwd_pkg::CTRL_PB_BIT];
   wire pb_clr = (cfg.rel_sel == kwd_pkg::REL_ANY) ? (scan_in.valid & ~make_hit) : brk_done;
   wire [1:0] sts_set = {brk_done, make_done};
   wire [1:0] sts_clr = wr_status ? w_byte[1:0] : 2'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         keyboard_power_button_status <= 1'b0;
         wake_event                   <= 1'b0;
         status                       <= kwd_pkg::RST_STATUS;
      end else if (ce) begin
         // A set in the same cycle as a clear wins.
         if (pb_set) begin
            keyboard_power_button_status <= 1'b1;
         end else if (pb_clr) begin
            keyboard_power_button_status <= 1'b0;
         end
         wake_event <= make_done & ctrl[kwd_pkg::CTRL_WAKE_BIT];
         status     <= (status & ~sts_clr) | sts_set;
      end
   end

   assign irq = |(status & mask);

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_lock_blocks_brk3: assert property (
      ce && cfg.lock && wr_any && (aw_idx == kwd_pkg::IDX_BRK3) |=> $stable(brk3))
      else $error("locked break byte 3 changed");

   a_lock_cfg_hold: assert property (
      ce && cfg.lock && !part_reset |=> cfg == $past(cfg))
      else $error("locked config changed");

   a_lock_cleared: assert property (
      ce && part_reset |=> !cfg.lock)
      else $error("partial reset left lock set");

   a_cfg_kept: assert property (
      ce && bus_reset && !wr_cfg |=> cfg[6:0] == $past(cfg[6:0]))
      else $error("bus reset altered config bits");

   a_pb_on_make: assert property (
      ce && make_done && ctrl[kwd_pkg::CTRL_PB_BIT] |=> keyboard_power_button_status)
      else $error("make match did not set button status");

   a_pb_rel_any: assert property (
      ce && (cfg.rel_sel == kwd_pkg::REL_ANY) && scan_in.valid && !make_hit |=>
      !keyboard_power_button_status)
      else $error("button status not dropped on other code");

   a_pb_rel_brk: assert property (
      ce && (cfg.rel_sel == kwd_pkg::REL_BREAK) && keyboard_power_button_status && !brk_done |=>
      keyboard_power_button_status)
      else $error("button status dropped without break");

   a_wake_pulse: assert property (
      ce && make_done && ctrl[kwd_pkg::CTRL_WAKE_BIT] |=> wake_event ##0 status[kwd_pkg::STS_MAKE_BIT])
      else $error("wake pulse missing after make match");

   a_brk3_len: assert property (
      (cfg.fmt == kwd_pkg::FMT_S2_MULTI) |-> (brk_len == 2'h3) && (brk_seq[2] == brk3))
      else $error("third break byte not in set 2 multi sequence");

endmodule

// Tracks one programmed byte sequence of up to three bytes.
module kwd_seq_track (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             ce,
   // Received byte and expected sequence
   input  wire kwd_pkg::kwd_scan_t scan,
   input  wire logic [2:0][7:0]  seq,
   input  wire logic [1:0]       len,
   // Match results
   output logic                  hit,
   output logic                  done
);
   logic [1:0] pos;
   wire  [7:0] expected = seq[pos];

   assign hit  = scan.valid & ((expected == 8'h00) | (scan.code == expected));
   assign done = hit & (pos >= (len - 2'h1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pos <= 2'h0;
      end else if (ce && scan.valid) begin
         pos <= done ? 2'h0 : (hit ? pos + 2'h1 : 2'h0);
      end
   end

   a_zero_matches: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && scan.valid && (expected == 8'h00) && !done |=> pos == $past(pos) + 2'h1)
      else $error("zero register byte did not advance the sequence");
endmodule

`default_nettype wire

//--- testbench/kwd_kbd_model.sv
// Keyboard side model that feeds scan bytes to the wake key decoder.
// Assumes the bench calls send right after a clock edge and one call at a time.
`timescale 1ns/1ns
`default_nettype none
module kwd_kbd_model (
   // Clock
   input  wire logic          aclk,
   // Scan stream toward the decoder
   output var kwd_pkg::kwd_scan_t scan
);
   initial scan = '{valid: 1'b0, code: 8'hA5};

   // Sends up to three bytes back to back, then releases the stream.
   task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n);
      logic [7:0] b [3];
      b = '{b0, b1, b2};
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         scan <= '{valid: 1'b1, code: b[i]};
      end
      @(posedge aclk);
      // An idle stream shows the inverted byte so a stale code is never mistaken for data.
      scan <= '{valid: 1'b0, code: ~b[n-1]};
   endtask
endmodule
`default_nettype wire

//--- testbench/kwd_wake_key_tb_top.sv
// Self-checking bench for the keyboard wake key decoder.
// Assumes the keyboard model drives scan bytes while the bench is the AXI4-Lite master.
`timescale 1ns/1ns
`default_nettype none
module kwd_wake_key_tb_top;
   logic                       aclk;
   logic                       aresetn;
   logic                       ce;
   logic [2:0]                 prst;
   kwd_pkg::kwd_scan_t         scan;
   logic                       pb;
   logic                       wake;
   logic                       irq;
   logic [kwd_pkg::ADDR_W-1:0] awaddr;
   logic [kwd_pkg::ADDR_W-1:0] araddr;
   logic [31:0]                wdata;
   logic [31:0]                rdata;
   logic [3:0]                 wstrb;
   logic [1:0]                 bresp;
   logic [1:0]                 rresp;
   logic [1:0]                 last_resp;
   logic                       awvalid, awready, wvalid, wready, bvalid, bready;
   logic                       arvalid, arready, rvalid, rready;
   int                         n_mismatch = 0;
   int                         tests_run = 0;
   logic [7:0]                 ri [9] = '{8'h5F, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h78, 8'h79, 8'h7A};
   logic [7:0]                 rv [9] = '{8'hE0, 8'h37, 8'hE0, 8'hF0, 8'h37, 8'h6C, 8'h00, 8'h00, 8'h03};

   kwd_kbd_model kbd_u (.aclk(aclk), .scan(scan));

   kwd_wake_key dut_u (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .standby_por(prst[0]), .main_por(prst[1]), .bus_reset(prst[2]), .scan_in(scan),
      .keyboard_power_button_status(pb), .wake_event(wake), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic timeout;
      n_mismatch++;
      $display("Error bus handshake expected answer seen none");
      report_and_stop();
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st = 4'hF);
      int n;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      bready <= 1'b0;
      last_resp = bresp;
      if (n == 40) timeout();
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er = kwd_pkg::RESP_OKAY);
      int n;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      rready <= 1'b0;
      if (n == 40) timeout();
      chk($sformatf("read data of index %h", idx), exp, rdata);
      chk($sformatf("read response of index %h", idx), 32'(er), 32'(rresp));
   endtask

   // Sends a byte sequence, then checks the outputs one edge later and the wake pulse end.
   task automatic key(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n,
                      input logic ep, input logic ew);
      kbd_u.send(b0, b1, b2, n);
      #1;
      chk("power button status", 32'(ep), 32'(pb));
      chk("wake event", 32'(ew), 32'(wake));
      @(posedge aclk);
      #1;
      chk("wake event end", 32'h0, 32'(wake));
   endtask

   initial begin
      aresetn = 1'b0;
      ce = 1'b1;
      prst = 3'h0;
      awaddr = '0;
      araddr = '0;
      wdata = 32'h0;
      wstrb = 4'h0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;

      for (int i = 0; i < 9; i++) rchk(ri[i], {24'h0, rv[i]});
      rchk(8'h10, 32'h0, kwd_pkg::RESP_SLVERR);
      wr(8'h10, 8'hFF);
      chk("unmapped write response", 32'(kwd_pkg::RESP_SLVERR), 32'(last_resp));
      $display("Test reset values done");

      key(8'hE0, 8'h37, 8'h00, 2, 1'b1, 1'b1);
      chk("masked interrupt", 32'h0, 32'(irq));
      wr(kwd_pkg::IDX_MASK, 8'h01);
      chk("mask write response", 32'(kwd_pkg::RESP_OKAY), 32'(last_resp));
      chk("unmasked interrupt", 32'h1, 32'(irq));
      wr(kwd_pkg::IDX_STATUS, 8'h01);
      chk("cleared interrupt", 32'h0, 32'(irq));
      key(8'hE0, 8'hF0, 8'h37, 3, 1'b0, 1'b0);
      rchk(kwd_pkg::IDX_STATUS, 32'h2);
      wr(kwd_pkg::IDX_STATUS, 8'h03);
      $display("Test default key done");

      wr(kwd_pkg::IDX_CFG, 8'h4C);
      key(8'hE0, 8'h37, 8'h00, 2, 1'b1, 1'b1);
      key(8'hE0, 8'h00, 8'h00, 1, 1'b1, 1'b0);
      key(8'h12, 8'h00, 8'h00, 1, 1'b0, 1'b0);
      $display("Test release on other code done");

      for (int f = 0; f < 4; f++) begin
         wr(kwd_pkg::IDX_CFG, 8'h40 | 8'(f << 2));
         if (f[0]) key(8'hE0, 8'h12, 8'h37, 3, 1'b0, 1'b0);
         key(f[0] ? 8'hE0 : 8'h37, 8'h37, 8'h00, f[0] ? 2 : 1, 1'b1, 1'b1);
         key(8'h12, 8'h00, 8'h00, 1, 1'b0, 1'b0);
      end
      $display("Test formats done");

      wr(kwd_pkg::IDX_CTRL, 8'h01);
      key(8'hE0, 8'h37, 8'h00, 2, 1'b0, 1'b1);
      wr(kwd_pkg::IDX_CTRL, 8'h02);
      key(8'hE0, 8'h37, 8'h00, 2, 1'b1, 1'b0);
      key(8'h12, 8'h00, 8'h00, 1, 1'b0, 1'b0);
      wr(kwd_pkg::IDX_CTRL, 8'h03);
      $display("Test event enables done");

      // With the enable low the trackers are frozen, so a full make sequence is not seen.
      @(posedge aclk);
      ce <= 1'b0;
      key(8'hE0, 8'h37, 8'h00, 2, 1'b0, 1'b0);
      @(posedge aclk);
      ce <= 1'b1;
      $display("Test clock enable done");

      wr(kwd_pkg::IDX_MAKE2, 8'h00);
      key(8'hE0, 8'h5A, 8'h00, 2, 1'b1, 1'b1);
      key(8'h12, 8'h00, 8'h00, 1, 1'b0, 1'b0);
      wr(kwd_pkg::IDX_MAKE2, 8'h37);
      wr(kwd_pkg::IDX_MAKE2, 8'h11, 4'hE);
      rchk(kwd_pkg::IDX_MAKE2, 32'h37);
      $display("Test any-code byte done");

      wr(kwd_pkg::IDX_CFG, 8'hCC);
      for (int i = 0; i < 6; i++) begin
         wr(ri[i], 8'h00);
         chk("locked write response", 32'(kwd_pkg::RESP_OKAY), 32'(last_resp));
         rchk(ri[i], (i == 5) ? 32'hCC : {24'h0, rv[i]});
      end
      $display("Test lock done");

      for (int k = 0; k < 3; k++) begin
         wr(kwd_pkg::IDX_CFG, 8'hCC);
         @(posedge aclk);
         prst <= 3'(1 << k);
         @(posedge aclk);
         prst <= 3'h0;
         rchk(kwd_pkg::IDX_CFG, 32'h4C);
      end
      $display("Test partial resets done");

      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(kwd_pkg::IDX_CFG, 32'h6C);
      rchk(kwd_pkg::IDX_MASK, 32'h0);
      $display("Test second full reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
